//--- power_table_select.sv
// picks the power setting table entry for the current transmit symbol
`timescale 1ns/100ps
`include "radio_cfg.svh"
module power_table_select
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] power_table_index,
  input wire logic ook_mode,
  input wire logic tx_symbol,
  output logic [2:0] power_entry_r
);
  import radio_pkg::*;

  logic [2:0] power_entry_nxt;

  always_comb
  begin
    power_entry_nxt = power_table_index;
    if (ook_mode && !tx_symbol)
    begin
      power_entry_nxt = `POWER_ENTRY_ZERO;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      power_entry_r <= `POWER_ENTRY_ZERO;
    end
    else
    begin
      power_entry_r <= power_entry_nxt;
    end
  end
endmodule : power_table_select

//--- radio_cfg.svh
// offsets, field positions, reset values and masks of the front-end and synth registers
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH
`define APB_ADDR_W 8
`define REG_COUNT 5
// register indices; byte address is four times the index
`define IDX_RX_FRONTEND_BIAS 8'h21
`define IDX_TX_FRONTEND_CONFIG 8'h22
`define IDX_SYNTH_CAL_CHARGE_PUMP 8'h23
`define IDX_SYNTH_CAL_VCO_CURRENT 8'h24
`define IDX_SYNTH_CAL_COARSE_TUNE 8'h25
`define RST_RX_FRONTEND_BIAS 8'h56
`define RST_TX_FRONTEND_CONFIG 8'h10
`define RST_SYNTH_CAL_CHARGE_PUMP 8'hA9
`define RST_SYNTH_CAL_VCO_CURRENT 8'h0A
`define RST_SYNTH_CAL_COARSE_TUNE 8'h20
`define MASK_RX_FRONTEND_BIAS 8'hFF
`define MASK_TX_FRONTEND_CONFIG 8'h37
`define MASK_SYNTH_CAL_CHARGE_PUMP 8'hFF
`define MASK_SYNTH_CAL_VCO_CURRENT 8'h3F
`define MASK_SYNTH_CAL_COARSE_TUNE 8'h3F
`define POS_RX_AMP_BIAS 6
`define POS_AMP_TO_MIXER_BIAS 4
`define POS_RX_LO_BUFFER_BIAS 2
`define POS_MIXER_BIAS 0
`define POS_TX_LO_BUFFER_BIAS 4
`define POS_POWER_TABLE_INDEX 0
`define POS_CP_CONFIG 6
`define POS_CP_CAL_ENABLE 4
`define POS_CP_CURRENT 0
`define POS_VCO_CORE_HIGH 5
`define POS_VCO_CURRENT 0
`define POS_COARSE_TUNE 0
`define POWER_ENTRY_ZERO 3'h0
`endif

//--- radio_frontend_synth_cal_regs.sv
// apb register slice for front-end bias and synthesizer calibration results
`timescale 1ns/100ps
`include "radio_cfg.svh"
module radio_frontend_synth_cal_regs
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_done,
  input wire radio_pkg::cal_result_type cal_result,
  output logic cp_cal_stage_enable,
  output radio_pkg::frontend_bias_type frontend_bias,
  output radio_pkg::synth_settings_type synth_settings,
  input wire logic ook_mode,
  input wire logic tx_symbol,
  output logic [2:0] power_entry
);
  import radio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address map

  localparam int RX = 0;
  localparam int TX = 1;
  localparam int CP = 2;
  localparam int VCO = 3;
  localparam int CT = 4;

  localparam logic [7:0] ADDR_RX = 8'(`IDX_RX_FRONTEND_BIAS * 4);
  localparam logic [7:0] ADDR_TX = 8'(`IDX_TX_FRONTEND_CONFIG * 4);
  localparam logic [7:0] ADDR_CP = 8'(`IDX_SYNTH_CAL_CHARGE_PUMP * 4);
  localparam logic [7:0] ADDR_VCO = 8'(`IDX_SYNTH_CAL_VCO_CURRENT * 4);
  localparam logic [7:0] ADDR_CT = 8'(`IDX_SYNTH_CAL_COARSE_TUNE * 4);

  localparam logic [7:0] RST_VAL [`REG_COUNT] = '{
    `RST_RX_FRONTEND_BIAS,
    `RST_TX_FRONTEND_CONFIG,
    `RST_SYNTH_CAL_CHARGE_PUMP,
    `RST_SYNTH_CAL_VCO_CURRENT,
    `RST_SYNTH_CAL_COARSE_TUNE
  };

  // reserved positions are cleared by the mask on every write
  localparam logic [7:0] WR_MASK [`REG_COUNT] = '{
    `MASK_RX_FRONTEND_BIAS,
    `MASK_TX_FRONTEND_CONFIG,
    `MASK_SYNTH_CAL_CHARGE_PUMP,
    `MASK_SYNTH_CAL_VCO_CURRENT,
    `MASK_SYNTH_CAL_COARSE_TUNE
  };

  logic [7:0] reg_r [`REG_COUNT];
  logic [7:0] reg_nxt [`REG_COUNT];
  logic [`REG_COUNT-1:0] hit;
  logic mapped;
  logic setup_phase;
  logic access_wr;
  logic [7:0] rd_mux;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic cp_stage_on;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  always_comb
  begin
    hit = '0;
    if (paddr == ADDR_RX)
    begin
      hit[RX] = 1'b1;
    end
    else if (paddr == ADDR_TX)
    begin
      hit[TX] = 1'b1;
    end
    else if (paddr == ADDR_CP)
    begin
      hit[CP] = 1'b1;
    end
    else if (paddr == ADDR_VCO)
    begin
      hit[VCO] = 1'b1;
    end
    else if (paddr == ADDR_CT)
    begin
      hit[CT] = 1'b1;
    end
  end

  assign mapped = |hit;
  assign setup_phase = psel && !penable;
  // only lane 0 carries register bits; other lanes are don't-care on writes
  assign access_wr = psel && penable && pwrite && pstrb[0];
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  assign cp_stage_on = reg_r[CP][`POS_CP_CAL_ENABLE +: 2] != 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++)
    begin : g_reg
      always_comb
      begin
        reg_nxt[gi] = reg_r[gi];
        if (access_wr && hit[gi])
        begin
          reg_nxt[gi] = pwdata[7:0] & WR_MASK[gi];
        end
        // a completing calibration wins over a same-cycle write of its fields
        if (cal_done)
        begin
          if (gi == CP && cp_stage_on)
          begin
            reg_nxt[gi][`POS_CP_CURRENT +: 4] = cal_result.cp_current;
          end
          if (gi == VCO)
          begin
            reg_nxt[gi][`POS_VCO_CURRENT +: 5] = cal_result.vco_current;
          end
          if (gi == CT)
          begin
            reg_nxt[gi][`POS_COARSE_TUNE +: 6] = cal_result.coarse_tune;
          end
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          reg_r[gi] <= RST_VAL[gi];
        end
        else
        begin
          reg_r[gi] <= reg_nxt[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb
  begin
    rd_mux = 8'h00;
    for (int i = 0; i < `REG_COUNT; i++)
    begin
      if (hit[i])
      begin
        rd_mux = reg_r[i];
      end
    end
  end

  // read data is sampled in the setup cycle and shown through the access cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup_phase)
    begin
      prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pslverr_r <= 1'b0;
    end
    else if (setup_phase)
    begin
      pslverr_r <= !mapped;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // settings to the analog front end and synthesizer

  assign frontend_bias.rx_amp_bias = reg_r[RX][`POS_RX_AMP_BIAS +: 2];
  assign frontend_bias.amp_to_mixer_bias = reg_r[RX][`POS_AMP_TO_MIXER_BIAS +: 2];
  assign frontend_bias.rx_lo_buffer_bias = reg_r[RX][`POS_RX_LO_BUFFER_BIAS +: 2];
  assign frontend_bias.mixer_bias = reg_r[RX][`POS_MIXER_BIAS +: 2];
  assign frontend_bias.tx_lo_buffer_bias = reg_r[TX][`POS_TX_LO_BUFFER_BIAS +: 2];

  assign cp_cal_stage_enable = cp_stage_on;

  // the synthesizer runs on whatever the registers hold, calibrated or written
  assign synth_settings.cp_config = reg_r[CP][`POS_CP_CONFIG +: 2];
  assign synth_settings.cp_current = reg_r[CP][`POS_CP_CURRENT +: 4];
  assign synth_settings.vco_core_high_select = reg_r[VCO][`POS_VCO_CORE_HIGH];
  assign synth_settings.vco_current = reg_r[VCO][`POS_VCO_CURRENT +: 5];
  assign synth_settings.coarse_tune = reg_r[CT][`POS_COARSE_TUNE +: 6];

  power_table_select i_power_table_select
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_table_index(reg_r[TX][`POS_POWER_TABLE_INDEX +: 3]),
    .ook_mode(ook_mode),
    .tx_symbol(tx_symbol),
    .power_entry_r(power_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic wr_vco;
  logic wr_ct;
  logic wr_cp;
  assign wr_vco = access_wr && hit[VCO];
  assign wr_ct = access_wr && hit[CT];
  assign wr_cp = access_wr && hit[CP];
  // write checks on calibrated fields leave out cal_done cycles, where the calibration result takes its field

  chk_rx_bias_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> frontend_bias.rx_amp_bias == 2'h1 && frontend_bias.amp_to_mixer_bias == 2'h1
      && frontend_bias.rx_lo_buffer_bias == 2'h1 && frontend_bias.mixer_bias == 2'h2)
    else $error("rx bias fields wrong after reset");

  chk_tx_lo_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> frontend_bias.tx_lo_buffer_bias == 2'h1 && reg_r[TX][2:0] == 3'h0)
    else $error("tx register wrong after reset");

  chk_power_index_follow: assert property (!ook_mode
    |=> power_entry == $past(reg_r[TX][2:0]))
    else $error("power entry does not follow the index");

  chk_ook_zero_entry: assert property (ook_mode && !tx_symbol |=> power_entry == 3'h0)
    else $error("ook zero symbol did not use entry zero");

  chk_ook_one_entry: assert property (ook_mode && tx_symbol
    |=> power_entry == $past(reg_r[TX][2:0]))
    else $error("ook one symbol used the wrong entry");

  chk_cp_stage_skip: assert property (cal_done && !cp_cal_stage_enable && !wr_cp
    |=> $stable(synth_settings.cp_current))
    else $error("charge pump result changed with its stage disabled");

  chk_cp_result_load: assert property (cal_done && cp_cal_stage_enable
    |=> synth_settings.cp_current == $past(cal_result.cp_current))
    else $error("charge pump result not loaded");

  chk_vco_core_write: assert property (wr_vco && !cal_done
    |=> synth_settings.vco_core_high_select == $past(pwdata[5]))
    else $error("vco core select not written");

  chk_vco_result_load: assert property (cal_done
    |=> synth_settings.vco_current == $past(cal_result.vco_current))
    else $error("vco current result not loaded");

  chk_coarse_result_load: assert property (cal_done ##1 !cal_done && !wr_ct
    |=> synth_settings.coarse_tune == $past(cal_result.coarse_tune, 2))
    else $error("coarse tune result not loaded or lost");

  chk_result_readback: assert property (setup_phase && hit[CT]
    ##1 psel && penable |-> prdata == {26'h000_0000, $past(synth_settings.coarse_tune)})
    else $error("coarse tune readback mismatch");

  chk_override_used: assert property (wr_ct && !cal_done
    |=> synth_settings.coarse_tune == $past(pwdata[5:0]))
    else $error("written coarse tune not used");

  chk_reserved_zero: assert property (reg_r[TX][7:6] == 2'h0 && reg_r[TX][3] == 1'b0
    && reg_r[VCO][7:6] == 2'h0 && reg_r[CT][7:6] == 2'h0 && prdata[31:8] == 24'h00_0000)
    else $error("reserved bits not zero");

  chk_no_spurious_update: assert property (!cal_done && !wr_vco
    |=> $stable(reg_r[VCO]))
    else $error("vco register changed without cause");

  chk_rx_write_lands: assert property (access_wr && hit[RX]
    |=> reg_r[RX] == $past(pwdata[7:0]))
    else $error("rx bias write did not land");

  chk_tx_lo_write: assert property (access_wr && hit[TX]
    |=> frontend_bias.tx_lo_buffer_bias == $past(pwdata[5:4]))
    else $error("tx lo buffer bias not written");

  chk_cp_enable_write: assert property (wr_cp
    |=> cp_cal_stage_enable == ($past(pwdata[5:4]) != 2'h0))
    else $error("charge pump stage enable does not follow its field");

  chk_cp_override: assert property (wr_cp && !cal_done
    |=> synth_settings.cp_current == $past(pwdata[3:0]))
    else $error("written charge pump current not used");

  chk_vco_override: assert property (wr_vco && !cal_done
    |=> synth_settings.vco_current == $past(pwdata[4:0]))
    else $error("written vco current not used");

  chk_tx_write_masked: assert property (access_wr && hit[TX]
    |=> reg_r[TX] == ($past(pwdata[7:0]) & `MASK_TX_FRONTEND_CONFIG))
    else $error("tx register reserved bits not cleared on write");

  chk_unmapped_err: assert property (setup_phase && !mapped
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_mapped_no_err: assert property (setup_phase && mapped
    |=> !pslverr)
    else $error("mapped access flagged as error");

  cov_calibration: cover property (cal_done && cp_cal_stage_enable ##1 psel && penable && hit[CP]);
  cov_hop_write: cover property (wr_cp ##[1:8] wr_vco ##[1:8] wr_ct);
  cov_ook_toggle: cover property (ook_mode && tx_symbol ##1 ook_mode && !tx_symbol);
  cov_unmapped: cover property (psel && penable && pslverr);
  cov_cp_skip: cover property (cal_done && !cp_cal_stage_enable);
endmodule : radio_frontend_synth_cal_regs

//--- radio_frontend_synth_cal_regs_test.sv
// self-checking bench for the front-end bias and synth calibration register slice
`timescale 1ns/100ps
`include "radio_cfg.svh"
module radio_frontend_synth_cal_regs_test;
  import radio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic clk_sys;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`APB_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cal_done;
  cal_result_type cal_result;
  logic cp_cal_stage_enable;
  frontend_bias_type frontend_bias;
  synth_settings_type synth_settings;
  logic ook_mode;
  logic tx_symbol;
  logic [2:0] power_entry;
  int bad_count;
  int checks;
  int cycles = 0;
  logic [31:0] rd_data;
  logic rd_err;
  logic [7:0] idx_tab [5] = '{`IDX_RX_FRONTEND_BIAS, `IDX_TX_FRONTEND_CONFIG,
    `IDX_SYNTH_CAL_CHARGE_PUMP, `IDX_SYNTH_CAL_VCO_CURRENT, `IDX_SYNTH_CAL_COARSE_TUNE};
  logic [7:0] rst_tab [5] = '{8'h56, 8'h10, 8'hA9, 8'h0A, 8'h20};
  logic [7:0] mask_tab [5] = '{8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h3F};

  radio_frontend_synth_cal_regs i_radio_frontend_synth_cal_regs
  (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cal_done(cal_done), .cal_result(cal_result),
    .cp_cal_stage_enable(cp_cal_stage_enable), .frontend_bias(frontend_bias),
    .synth_settings(synth_settings), .ook_mode(ook_mode), .tx_symbol(tx_symbol),
    .power_entry(power_entry)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ceiling is far above the roughly 120 cycles the sequence needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] addr_of(input logic [7:0] idx);
    addr_of = {idx[5:0], 2'h0};
  endfunction : addr_of

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks = checks + 1;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      bad_count = bad_count + 1;
    end
  endtask : check

  // one full apb transfer; an idle edge first keeps drives one per time step
  task automatic acc(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
    input logic [3:0] st);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1)
    begin
      @(posedge clk_sys);
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : acc

  task automatic cal(input cal_result_type r);
    @(posedge clk_sys);
    cal_result <= r;
    cal_done <= 1'h1;
    @(posedge clk_sys);
    cal_done <= 1'h0;
  endtask : cal

  task automatic rd_chk(input int i, input logic [7:0] exp);
    acc(1'h0, addr_of(idx_tab[i]), 32'h0, 4'h0);
    check("register", {24'h0, exp}, rd_data);
    check("pslverr", 32'h0, {31'h0, rd_err});
  endtask : rd_chk

  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    checks = 0;
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cal_done = 1'h0;
    cal_result = '0;
    ook_mode = 1'h0;
    tx_symbol = 1'h0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    @(negedge clk_sys);
    check("frontend_bias", {22'h0, 10'h159}, {22'h0, frontend_bias});
    check("synth_settings", {14'h0, 2'h2, 4'h9, 1'h0, 5'h0A, 6'h20},
      {14'h0, synth_settings});
    check("cp enable", 32'h1, {31'h0, cp_cal_stage_enable});
    for (int i = 0; i < 5; i++)
      rd_chk(i, rst_tab[i]);
    // all ones shows which bits exist; reserved ones must stay zero
    for (int i = 0; i < 5; i++)
    begin
      acc(1'h1, addr_of(idx_tab[i]), 32'hFFFFFFFF, 4'hF);
      rd_chk(i, mask_tab[i]);
    end
    @(negedge clk_sys);
    check("frontend_bias", {22'h0, 10'h3FF}, {22'h0, frontend_bias});
    check("synth_settings", 32'h3FFFF, {14'h0, synth_settings});
    acc(1'h1, addr_of(idx_tab[0]), 32'h0, 4'hE);
    rd_chk(0, 8'hFF);
    // unmapped neighbours and a misaligned address are refused
    acc(1'h1, 8'h98, 32'hFF, 4'hF);
    check("unmapped err", 32'h1, {31'h0, rd_err});
    acc(1'h0, 8'h80, 32'h0, 4'h0);
    check("unmapped err", 32'h1, {31'h0, rd_err});
    check("unmapped data", 32'h0, rd_data);
    acc(1'h0, 8'h85, 32'h0, 4'h0);
    check("misaligned err", 32'h1, {31'h0, rd_err});
    // power index 5, then each keying case
    acc(1'h1, addr_of(idx_tab[1]), 32'h05, 4'hF);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      ook_mode <= k[1];
      tx_symbol <= k[0];
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("power_entry", (k == 2) ? 32'h0 : 32'h5, {29'h0, power_entry});
    end
    check("tx lo bias", 32'h0, {30'h0, frontend_bias.tx_lo_buffer_bias});
    // config field loaded before calibration; enable field 11 keeps the stage on
    acc(1'h1, addr_of(idx_tab[2]), 32'hB0, 4'h1);
    cal('{cp_current: 4'h3, vco_current: 5'h15, coarse_tune: 6'h2A});
    rd_chk(2, 8'hB3);
    rd_chk(3, 8'h35);
    rd_chk(4, 8'h2A);
    // stage disabled: written charge pump current must survive the next run
    acc(1'h1, addr_of(idx_tab[2]), 32'hC5, 4'hF);
    @(negedge clk_sys);
    check("cp enable", 32'h0, {31'h0, cp_cal_stage_enable});
    cal('{cp_current: 4'hE, vco_current: 5'h01, coarse_tune: 6'h3F});
    rd_chk(2, 8'hC5);
    rd_chk(3, 8'h21);
    rd_chk(4, 8'h3F);
    // hop: saved results written back become the synthesizer settings
    acc(1'h1, addr_of(idx_tab[2]), 32'hF3, 4'hF);
    acc(1'h1, addr_of(idx_tab[3]), 32'h35, 4'hF);
    acc(1'h1, addr_of(idx_tab[4]), 32'h2A, 4'hF);
    @(negedge clk_sys);
    check("synth_settings", {14'h0, 2'h3, 4'h3, 1'h1, 5'h15, 6'h2A},
      {14'h0, synth_settings});
    test_done();
  end
endmodule : radio_frontend_synth_cal_regs_test

//--- radio_pkg.sv
// types shared by the front-end and synthesizer calibration register slice
package radio_pkg;
  typedef struct packed
  {
    logic [1:0] rx_amp_bias;
    logic [1:0] amp_to_mixer_bias;
    logic [1:0] rx_lo_buffer_bias;
    logic [1:0] mixer_bias;
    logic [1:0] tx_lo_buffer_bias;
  } frontend_bias_type;

  typedef struct packed
  {
    logic [1:0] cp_config;
    logic [3:0] cp_current;
    logic vco_core_high_select;
    logic [4:0] vco_current;
    logic [5:0] coarse_tune;
  } synth_settings_type;

  typedef struct packed
  {
    logic [3:0] cp_current;
    logic [4:0] vco_current;
    logic [5:0] coarse_tune;
  } cal_result_type;
endpackage : radio_pkg
